// ===== microstep_translator_defs.svh
// Constants for the microstep translator: widths, reset values and step sizes.
`ifndef MICROSTEP_TRANSLATOR_DEFS_SVH
`define MICROSTEP_TRANSLATOR_DEFS_SVH
`define ANGLE_WIDTH 6
`define ANGLE_COUNT 64
`define DAC_WIDTH 6
`define ANGLE_RESET 6'h00
`define SELECT_RESET 2'h0
`define FULL_STEP_SIZE 6'h10
`define HALF_STEP_SIZE 6'h08
`define QUARTER_STEP_SIZE 6'h04
`define SIXTEENTH_STEP_SIZE 6'h01
`define FULL_STEP_OFFSET 6'h08
`define STEP_DEGREES_X1000 5625
`endif

// ===== microstep_translator_pkg.sv
// Types shared by the microstep translator files.
package microstep_translator_pkg;
    typedef enum logic [1:0] {
        RES_FULL = 2'b00,
        RES_HALF = 2'b01,
        RES_QUARTER = 2'b10,
        RES_SIXTEENTH = 2'b11
    } resolution_type;
    typedef struct packed {
        logic [5:0] magnitude;
        logic negative;
    } phase_current_type;
    typedef struct packed {
        phase_current_type phaseA;
        phase_current_type phaseB;
    } table_entry_type;
    typedef enum logic [1:0] {
        SRC_IDLE = 2'b00,
        SRC_STEP = 2'b01,
        SRC_SERIAL = 2'b10
    } move_source_type;
endpackage

// ===== input_sync.sv
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
module input_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= meta_d;
            syncOut <= sync_d;
        end
    end
endmodule

// ===== phase_table_rom.sv
// Registered-output phase current table, one quadrant stored and mirrored.
`timescale 1ns/1ps
`include "microstep_translator_defs.svh"
module phase_table_rom
    import microstep_translator_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [5:0] angle,
    output table_entry_type entry_q
);
    // Quarter sine, 0..16 of full scale 63; entry 16 is full scale.
    function automatic logic [5:0] quarter(input logic [4:0] i);
        logic [5:0] v;
        v = 6'h00;
        unique case (i)
            5'd0: v = 6'h00;
            5'd1: v = 6'h06;
            5'd2: v = 6'h0C;
            5'd3: v = 6'h12;
            5'd4: v = 6'h18;
            5'd5: v = 6'h1D;
            5'd6: v = 6'h23;
            5'd7: v = 6'h27;
            5'd8: v = 6'h2C;
            5'd9: v = 6'h30;
            5'd10: v = 6'h34;
            5'd11: v = 6'h37;
            5'd12: v = 6'h3A;
            5'd13: v = 6'h3C;
            5'd14: v = 6'h3E;
            5'd15: v = 6'h3E;
            default: v = 6'h3F;
        endcase
        return v;
    endfunction
    // Magnitude of sin over a 64-step cycle, folded into one quadrant.
    function automatic logic [5:0] sineMag(input logic [5:0] a);
        logic [4:0] q;
        // The second quadrant runs the stored quarter backwards, 16 down to 1.
        q = a[4] ? 5'(6'h10 - {2'b00, a[3:0]}) : {1'b0, a[3:0]};
        return quarter(q);
    endfunction
    table_entry_type entry_d;
    logic [5:0] angleB;
    always_comb begin
        angleB = 6'(angle + 6'h10);
        // Angle zero puts phase B at plus full scale and phase A at zero.
        entry_d.phaseA.magnitude = sineMag(angle);
        entry_d.phaseA.negative = angle[5] && angle != 6'h20;
        entry_d.phaseB.magnitude = sineMag(angleB);
        entry_d.phaseB.negative = angleB[5] && angleB != 6'h20;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            entry_q <= '0;
        end else begin
            entry_q <= entry_d;
        end
    end
endmodule

// ===== microstep_translator.sv
// Step and direction translator driving the phase current setpoints.
//
// Contract
// - Sixty-four step angle numbers index the table.
// - Each entry gives magnitude and sign per phase.
// - Each phase setpoint is six bits wide.
// - Angle zero: B full, A zero; 5.625 degrees.
// - Select code picks full, half, quarter, sixteenth.
// - Effective select bit is pin OR register.
// - Register select bits reset to zero.
// - Select bits ignored for serial step changes.
// - Sixteenth mode moves one per step edge.
// - Full step uses only 8, 24, 40, 56.
// - Half step uses multiples of eight.
// - Quarter step uses multiples of four.
// - New resolution applies from next step edge.
// - After change, move to nearest allowed position.
// - From 59 forward: 60, 0 or 8.
// - Step moves fixed; serial moves vary per write.
// - Index arithmetic wraps modulo sixty-four.
// - Serial value is six-bit two's complement, added.
// - Serial change applies on strobe rising edge; dropped if a step edge comes in the same cycle.
`timescale 1ns/1ps
`include "microstep_translator_defs.svh"
module microstep_translator
    import microstep_translator_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic stepPin,
    input wire logic directionPin,
    input wire logic microstep_select_low,
    input wire logic microstep_select_high,
    input wire logic serial_strobe_n,
    input wire logic runWriteSelect,
    input wire logic [5:0] step_change_value,
    input wire logic configWrite,
    input wire logic [1:0] configSelectBits,
    output logic [5:0] stepAngle_q,
    output logic [5:0] phaseACurrent_q,
    output logic phaseANegative_q,
    output logic [5:0] phaseBCurrent_q,
    output logic phaseBNegative_q,
    output logic [1:0] resolution_q
);
    // Pin levels and strobe come from outside and pass two flops first.
    // The strobe is synchronised inverted, so that the synchroniser's reset level
    // equals the strobe's idle level and no false edge follows reset.
    logic [4:0] pinSync;
    input_sync #(.WIDTH(5)) pinSyncer (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .asyncIn({stepPin, directionPin, microstep_select_low, microstep_select_high,
            ~serial_strobe_n}),
        .syncOut(pinSync)
    );
    logic stepS;
    logic dirS;
    logic selLowS;
    logic selHighS;
    logic strobeLowS;
    always_comb begin
        stepS = pinSync[4];
        dirS = pinSync[3];
        selLowS = pinSync[2];
        selHighS = pinSync[1];
        strobeLowS = pinSync[0];
    end

    // Edge detectors and the register copy of the select bits.
    logic stepPrev_q;
    logic stepPrev_d;
    logic strobePrev_q;
    logic strobePrev_d;
    logic [1:0] selectReg_q;
    logic [1:0] selectReg_d;
    logic stepRise;
    logic strobeRise;
    always_comb begin
        stepPrev_d = stepS;
        strobePrev_d = strobeLowS;
        stepRise = stepS && !stepPrev_q;
        strobeRise = !strobeLowS && strobePrev_q;
        selectReg_d = configWrite ? configSelectBits : selectReg_q;
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stepPrev_q <= 1'b0;
            strobePrev_q <= 1'b0;
            selectReg_q <= `SELECT_RESET;
        end else begin
            stepPrev_q <= stepPrev_d;
            strobePrev_q <= strobePrev_d;
            selectReg_q <= selectReg_d;
        end
    end

    // Resolution is sampled only at a step edge, so a select change between
    // edges takes effect on the next one.
    resolution_type resolution;
    always_comb begin
        resolution = resolution_type'({selHighS | selectReg_q[1],
            selLowS | selectReg_q[0]});
    end

    // Next allowed position in the given direction from any index.
    // Positions are offset + k*size; forward rounds up past, reverse down past.
    function automatic logic [5:0] nextPosition(input logic [5:0] cur,
            input resolution_type res, input logic forward);
        logic [5:0] size;
        logic [5:0] offset;
        logic [5:0] rel;
        logic [5:0] mask;
        logic [5:0] base;
        size = `SIXTEENTH_STEP_SIZE;
        offset = 6'h00;
        unique case (res)
            RES_FULL: begin
                size = `FULL_STEP_SIZE;
                offset = `FULL_STEP_OFFSET;
            end
            RES_HALF: size = `HALF_STEP_SIZE;
            RES_QUARTER: size = `QUARTER_STEP_SIZE;
            RES_SIXTEENTH: size = `SIXTEENTH_STEP_SIZE;
        endcase
        mask = 6'(~(size - 6'h01));
        rel = 6'(cur - offset);
        base = rel & mask;
        if (forward) begin
            base = 6'(base + size);
        end else if (base == rel) begin
            base = 6'(base - size);
        end
        return 6'(base + offset);
    endfunction

    // Step angle number: the step pin moves by resolution, the serial run
    // write adds its signed value without regard to the select bits unless a step edge comes in the same cycle.
    move_source_type source;
    logic [5:0] stepAngle_d;
    logic [1:0] resolution_d;
    always_comb begin
        source = SRC_IDLE;
        stepAngle_d = stepAngle_q;
        resolution_d = resolution_q;
        if (stepRise) begin
            source = SRC_STEP;
        end else if (strobeRise && runWriteSelect) begin
            source = SRC_SERIAL;
        end
        unique case (source)
            SRC_STEP: begin
                stepAngle_d = nextPosition(stepAngle_q, resolution, dirS);
                resolution_d = resolution;
            end
            SRC_SERIAL: begin
                stepAngle_d = 6'(stepAngle_q + step_change_value);
            end
            SRC_IDLE: stepAngle_d = stepAngle_q;
            default: stepAngle_d = stepAngle_q;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stepAngle_q <= `ANGLE_RESET;
            resolution_q <= `SELECT_RESET;
        end else begin
            stepAngle_q <= stepAngle_d;
            resolution_q <= resolution_d;
        end
    end

    // Current table lookup; one cycle later than the index.
    table_entry_type entry;
    phase_table_rom phaseTable (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .angle(stepAngle_q),
        .entry_q(entry)
    );
    always_comb begin
        phaseACurrent_q = entry.phaseA.magnitude;
        phaseANegative_q = entry.phaseA.negative;
        phaseBCurrent_q = entry.phaseB.magnitude;
        phaseBNegative_q = entry.phaseB.negative;
    end

    // Checks.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_sixteenth_move: assert property (stepRise && resolution == RES_SIXTEENTH |=>
        stepAngle_q == 6'($past(stepAngle_q) + ($past(dirS) ? 6'h01 : 6'h3F)))
        else $error("sixteenth step did not move by one");
    a_full_positions: assert property (stepRise && resolution == RES_FULL |=>
        stepAngle_q[3:0] == 4'h8)
        else $error("full step left the 45 degree positions");
    a_half_positions: assert property (stepRise && resolution == RES_HALF |=>
        stepAngle_q[2:0] == 3'h0)
        else $error("half step off a multiple of eight");
    a_quarter_positions: assert property (stepRise && resolution == RES_QUARTER |=>
        stepAngle_q[1:0] == 2'h0)
        else $error("quarter step off a multiple of four");
    a_forward_nearest: assert property (stepRise && dirS
        && resolution == RES_QUARTER && stepAngle_q == 6'd59 |=> stepAngle_q == 6'd60)
        else $error("forward from 59 in quarter step did not reach 60");
    a_half_from_59: assert property (stepRise && dirS
        && resolution == RES_HALF && stepAngle_q == 6'd59 |=> stepAngle_q == 6'd0)
        else $error("forward from 59 in half step did not reach 0");
    a_full_from_59: assert property (stepRise && dirS
        && resolution == RES_FULL && stepAngle_q == 6'd59 |=> stepAngle_q == 6'd8)
        else $error("forward from 59 in full step did not reach 8");
    a_serial_add: assert property (!stepRise && strobeRise && runWriteSelect |=>
        stepAngle_q == 6'($past(stepAngle_q) + $past(step_change_value)))
        else $error("serial step change not added");
    a_idle_hold: assert property (!stepRise && !(strobeRise && runWriteSelect) |=>
        $stable(stepAngle_q))
        else $error("index moved without an edge");
    a_move_bounded: assert property (stepRise |=>
        (stepAngle_q != $past(stepAngle_q))
        && (6'(stepAngle_q - $past(stepAngle_q)) <= 6'h10
        || 6'($past(stepAngle_q) - stepAngle_q) <= 6'h10))
        else $error("step moved further than one full step");
    a_res_latched: assert property (stepRise |=> resolution_q == $past(resolution))
        else $error("resolution not taken at the step edge");
    a_select_reg: assert property (configWrite |=> selectReg_q == $past(configSelectBits))
        else $error("select register not written");

    c_full_step: cover property (stepRise && resolution == RES_FULL);
    c_wrap_fwd: cover property (stepRise && dirS && stepAngle_q == 6'd63
        && resolution == RES_SIXTEENTH);
    c_serial_neg: cover property (strobeRise && runWriteSelect && step_change_value[5]);
    c_res_change: cover property (stepRise ##[1:40] (stepRise && resolution != resolution_q));
endmodule

// ===== step_controller.sv
// Motion controller model that issues step pulses on request.
`timescale 1ns/1ps
module step_controller (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic doStep,
    output logic stepPin,
    output logic busy
);
    logic [2:0] count_q;
    logic [2:0] count_d;
    always_comb begin
        count_d = count_q;
        if (doStep && count_q == 3'h0) begin
            count_d = 3'h6;
        end else if (count_q != 3'h0) begin
            count_d = count_q - 3'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        count_q <= sys_rst ? 3'h0 : count_d;
    end
    // High lasts three cycles and low at least four, above the two-cycle minimum of the synchroniser.
    assign stepPin = count_q > 3'h3;
    assign busy = count_q != 3'h0;
endmodule

// ===== microstep_translator_bench.sv
// Self-checking bench for the microstep translator.
`timescale 1ns/1ps
module microstep_translator_bench;
    import microstep_translator_pkg::*;
    logic ref_clk, sys_rst, stepPin, directionPin, busy, doStep;
    logic microstep_select_low, microstep_select_high, serial_strobe_n, runWriteSelect;
    logic configWrite, phaseANegative_q, phaseBNegative_q;
    logic [1:0] configSelectBits, resolution_q, expRes;
    logic [5:0] step_change_value, stepAngle_q, phaseACurrent_q, phaseBCurrent_q, expAngle;
    int err_count, compares;
    microstep_translator microstep_translator_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .stepPin(stepPin), .directionPin(directionPin),
        .microstep_select_low(microstep_select_low),
        .microstep_select_high(microstep_select_high), .serial_strobe_n(serial_strobe_n),
        .runWriteSelect(runWriteSelect), .step_change_value(step_change_value),
        .configWrite(configWrite), .configSelectBits(configSelectBits),
        .stepAngle_q(stepAngle_q), .phaseACurrent_q(phaseACurrent_q),
        .phaseANegative_q(phaseANegative_q), .phaseBCurrent_q(phaseBCurrent_q),
        .phaseBNegative_q(phaseBNegative_q), .resolution_q(resolution_q));
    step_controller step_controller_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .doStep(doStep),
        .stepPin(stepPin), .busy(busy));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic stop_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic allowed(input logic [5:0] p, input logic [1:0] res);
        case (res)
            2'h0: return p[3:0] == 4'h8;
            2'h1: return p[2:0] == 3'h0;
            2'h2: return p[1:0] == 2'h0;
            default: return 1'b1;
        endcase
    endfunction
    // Nearest allowed position strictly beyond the current one, wrapping modulo 64.
    function automatic logic [5:0] next_pos(input logic [5:0] cur, input logic [1:0] res,
            input logic fwd);
        logic [5:0] p;
        p = cur;
        for (int i = 0; i < 64; i++) begin
            p = fwd ? p + 6'h01 : p - 6'h01;
            if (allowed(p, res)) return p;
        end
        return p;
    endfunction
    task automatic set_mode(input logic [1:0] m, input logic [1:0] eff);
        {microstep_select_high, microstep_select_low} = m;
        expRes = eff;
        tick(4);
    endtask
    task automatic do_step(input logic fwd);
        int n;
        directionPin = fwd;
        tick(4);
        doStep = 1'b1;
        tick(1);
        doStep = 1'b0;
        for (n = 0; n < 20 && busy === 1'b1; n++) tick(1);
        if (busy !== 1'b0) begin
            err_count++;
            stop_test();
        end
        tick(3);
        expAngle = next_pos(expAngle, expRes, fwd);
        check(stepAngle_q, expAngle);
        check(resolution_q, expRes);
    endtask
    task automatic serial_write(input logic [5:0] v, input logic sel);
        runWriteSelect = sel;
        step_change_value = v;
        serial_strobe_n = 1'b0;
        tick(3);
        serial_strobe_n = 1'b1;
        tick(3);
        runWriteSelect = 1'b0;
        tick(4);
        if (sel) expAngle = expAngle + v;
        check(stepAngle_q, expAngle);
    endtask
    task automatic set_angle(input logic [5:0] target);
        serial_write(target - expAngle, 1'b1);
    endtask
    task automatic test_reset();
        check(stepAngle_q, 8'h00);
        check(resolution_q, 8'h00);
        check({phaseANegative_q, phaseACurrent_q}, 8'h00);
        check({phaseBNegative_q, phaseBCurrent_q}, 8'h3F);
    endtask
    task automatic test_modes();
        for (int m = 0; m < 4; m++) begin
            set_mode(m[1:0], m[1:0]);
            for (int k = 0; k < 5; k++) do_step(1'b1);
            for (int k = 0; k < 3; k++) do_step(1'b0);
        end
    endtask
    task automatic test_serial();
        set_mode(2'h0, 2'h0);
        serial_write(6'h03, 1'b1);
        serial_write(6'h3B, 1'b1);
        serial_write(6'h05, 1'b0);
        set_angle(6'h20);
        check({phaseANegative_q, phaseACurrent_q}, 8'h00);
        check({phaseBNegative_q, phaseBCurrent_q}, 8'h7F);
        set_angle(6'h11);
        check({phaseANegative_q, phaseACurrent_q}, 8'h3E);
        check({phaseBNegative_q, phaseBCurrent_q}, 8'h46);
        set_mode(2'h3, 2'h3);
        set_angle(6'h00);
        do_step(1'b0);
        check(stepAngle_q, 8'h3F);
        do_step(1'b1);
    endtask
    task automatic test_change();
        logic [1:0] modes [3];
        logic [5:0] lands [3];
        modes = '{2'h2, 2'h1, 2'h0};
        lands = '{6'h3C, 6'h00, 6'h08};
        for (int i = 0; i < 3; i++) begin
            set_mode(2'h3, 2'h3);
            set_angle(6'h3B);
            set_mode(modes[i], modes[i]);
            do_step(1'b1);
            check(stepAngle_q, lands[i]);
        end
    endtask
    task automatic reg_case(input logic [1:0] bits, input logic [1:0] pins, input logic [1:0] eff);
        configSelectBits = bits;
        configWrite = 1'b1;
        tick(1);
        configWrite = 1'b0;
        set_mode(pins, eff);
        do_step(1'b1);
    endtask
    task automatic test_register();
        reg_case(2'h3, 2'h0, 2'h3);
        reg_case(2'h2, 2'h1, 2'h3);
        reg_case(2'h0, 2'h1, 2'h1);
        reg_case(2'h1, 2'h2, 2'h3);
        reg_case(2'h0, 2'h0, 2'h0);
        check(stepAngle_q[3:0], 4'h8);
    endtask
    initial begin
        {sys_rst, directionPin, doStep} = 3'h4;
        {microstep_select_low, microstep_select_high, configWrite, runWriteSelect} = 4'h0;
        serial_strobe_n = 1'b1;
        configSelectBits = 2'h0;
        step_change_value = 6'h00;
        expAngle = 6'h00;
        expRes = 2'h0;
        err_count = 0;
        compares = 0;
        tick(10);
        sys_rst = 1'b0;
        tick(3);
        test_reset();
        test_modes();
        test_serial();
        test_change();
        test_register();
        stop_test();
    end
endmodule
